// ---- core/rrie_exec.sv ----
// Execution unit for interrupt return, subroutine returns and rotate left through carry
//
// Functional notes
// - Interrupt return pops stack, loads popped top into PC, takes two cycles.
// - Interrupt return also sets global interrupt enable, bit 7 of control register.
// - Subroutine return pops stack into PC, two cycles, status flags untouched.
// - Return with literal writes the 8-bit immediate into the accumulator, flags untouched.
// - Return with literal also pops stack into PC, two cycles total.
// - Rotate left shifts file value left, old carry in, old top bit to carry.
// - Rotate destination bit 0 writes accumulator, 1 writes back to file register.
`timescale 1ns/1ps
`default_nettype none
module rrie_exec
(
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire rrie_pkg::rrie_req_t req,
   input  wire logic [12:0]        stack_top,
   input  wire logic               flags_wr_en,
   input  wire rrie_pkg::rrie_flags_t flags_wr_data,
   input  wire logic               irq_ctrl_wr_en,
   input  wire logic [7:0]         irq_ctrl_wr_data,
   output logic                    ready,
   output logic                    instr_done,
   output logic                    stack_pop,
   output logic [12:0]             pc,
   output logic [7:0]              acc,
   output rrie_pkg::rrie_flags_t   flags,
   output logic [7:0]              irq_control_reg,
   output rrie_pkg::rrie_fwr_t     file_wr
);
   import rrie_pkg::*;

   rrie_state_t  state_r;
   logic         ready_r;
   logic         done_r;
   logic         pop_r;
   logic [12:0]  pc_r;
   logic [7:0]   acc_r;
   rrie_flags_t  flags_r;
   logic [7:0]   irq_ctrl_r;
   rrie_fwr_t    fwr_r;
   rrie_op_t     op;
   logic         take;
   logic [7:0]   rot_val;
   logic [7:0]   lit;
   logic         dest;

   // Opcode classification
   function automatic rrie_op_t decode_op(input logic [13:0] opc);
      rrie_op_t r;
      r = OP_NONE;
      if (opc == OPC_IRQ_RET)
         r = OP_IRQ_RET;
      else if (opc == OPC_RETURN)
         r = OP_RETURN;
      else if ((opc & MSK_LIT_RET) == VAL_LIT_RET)
         r = OP_LIT_RET;
      else if ((opc & MSK_ROT_L) == VAL_ROT_L)
         r = OP_ROT_L;
      return r;
   endfunction : decode_op

   // True for the three opcodes that pop the call stack
   function automatic logic is_ret(input rrie_op_t o);
      return (o == OP_IRQ_RET) || (o == OP_RETURN) || (o == OP_LIT_RET);
   endfunction : is_ret

   // Issue decode and operand fields
   assign take    = req.valid && ready_r;
   assign op      = take ? decode_op(req.opcode) : OP_NONE;
   assign lit     = req.opcode[7:0];
   assign dest    = req.opcode[DEST_BIT];
   assign rot_val = {req.file_rd_data[MSB_BIT-1:0], flags_r.carry};

   // Two cycle sequencing for returns
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         ready_r <= 1'b1;
         done_r  <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               if (is_ret(op))
               begin
                  state_r <= ST_SECOND;
                  ready_r <= 1'b0;
               end
               else if (take)
                  done_r <= 1'b1; // Single cycle ops and unknown codes
            end
            ST_SECOND:
            begin
               state_r <= ST_IDLE;
               ready_r <= 1'b1;
               done_r  <= 1'b1;
            end
         endcase
      end
   end

   // Program counter and stack pop
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pc_r  <= RST_PC;
         pop_r <= 1'b0;
      end
      else
      begin
         pop_r <= 1'b0;
         if (is_ret(op))
         begin
            pc_r  <= stack_top;
            pop_r <= 1'b1;
         end
      end
   end

   // Accumulator
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         acc_r <= RST_ACC;
      else if (op == OP_LIT_RET)
         acc_r <= lit;
      else if (op == OP_ROT_L && !dest)
         acc_r <= rot_val;
   end

   // Status flags, write port loads all of them, among ops only rotate touches carry
   // returns hold flags
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         flags_r <= '0;
      else
      begin
         if (flags_wr_en)
            flags_r <= flags_wr_data;
         if (op == OP_ROT_L)
            flags_r.carry <= req.file_rd_data[MSB_BIT];
      end
   end

   // Interrupt control, hardware set wins over a write
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         irq_ctrl_r <= RST_IRQ_CTRL;
      else
      begin
         if (irq_ctrl_wr_en)
            irq_ctrl_r <= irq_ctrl_wr_data;
         if (op == OP_IRQ_RET)
            irq_ctrl_r[IRQ_EN_BIT] <= 1'b1;
      end
   end

   // File register write back
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         fwr_r <= '0;
      else
      begin
         fwr_r.en   <= (op == OP_ROT_L) && dest;
         fwr_r.addr <= req.opcode[FADDR_W-1:0];
         fwr_r.data <= rot_val;
      end
   end

   assign ready           = ready_r;
   assign instr_done      = done_r;
   assign stack_pop       = pop_r;
   assign pc              = pc_r;
   assign acc             = acc_r;
   assign flags           = flags_r;
   assign irq_control_reg = irq_ctrl_r;
   assign file_wr         = fwr_r;

   // Helper copies for checks
   logic [12:0]  top_q;
   logic [7:0]   fdat_q;
   logic         c_q;
   logic         fw_q;
   always_ff @(posedge core_clk)
   begin
      top_q  <= stack_top;
      fdat_q <= req.file_rd_data;
      c_q    <= flags_r.carry;
      fw_q   <= flags_wr_en;
   end

   sequence s_ret_issue;
      (op == OP_IRQ_RET) || (op == OP_RETURN) || (op == OP_LIT_RET);
   endsequence
   sequence s_ret_finish;
      !ready_r && !done_r ##1 ready_r && done_r;
   endsequence

   AST_RET_TWO_CYCLES: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_ret_issue |=> s_ret_finish)
      else $error("return did not finish in two cycles");
   AST_RET_PC_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_ret_issue |=> stack_pop && pc_r == $past(stack_top))
      else $error("pc not loaded from stack top");
   AST_IRQ_RET_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_IRQ_RET |=> irq_ctrl_r[IRQ_EN_BIT])
      else $error("global interrupt enable not set");
   AST_RETURN_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_RETURN && !flags_wr_en |=> $stable(flags_r) ##1 ready_r)
      else $error("subroutine return changed flags");
   AST_LIT_RET_ACC: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_LIT_RET |=> acc_r == $past(req.opcode[7:0]) && ($stable(flags_r.carry) || fw_q))
      else $error("literal not in accumulator");
   AST_LIT_RET_POP: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_LIT_RET |=> stack_pop && pc_r == top_q ##1 !stack_pop && done_r)
      else $error("literal return pop or timing wrong");
   AST_ROT_CARRY: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_ROT_L && !flags_wr_en |=> flags_r.carry == fdat_q[MSB_BIT] && done_r)
      else $error("rotate carry wrong");
   AST_ROT_DEST: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_ROT_L |=> (file_wr.en ? file_wr.data : acc_r) == {fdat_q[6:0], c_q}
                       && file_wr.en == $past(dest))
      else $error("rotate result misplaced");
   // arithmetic flags kept on interrupt return
   AST_IRQ_RET_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
      op == OP_IRQ_RET && !flags_wr_en |=> $stable(flags_r) && $stable(acc_r))
      else $error("interrupt return altered flags");
endmodule : rrie_exec
`default_nettype wire

// ---- core/rrie_pkg.sv ----
// Shared constants and carrier types for the return and rotate execution block
package rrie_pkg;
   // Instruction word geometry
   localparam int OPC_W       = 14;
   localparam int PC_W        = 13;
   localparam int DATA_W      = 8;
   localparam int FADDR_W     = 7;
   // Fixed opcodes and decode masks
   localparam logic [13:0] OPC_IRQ_RET    = 14'h0009;
   localparam logic [13:0] OPC_RETURN     = 14'h0008;
   localparam logic [13:0] MSK_LIT_RET    = 14'h3C00;
   localparam logic [13:0] VAL_LIT_RET    = 14'h3400;
   localparam logic [13:0] MSK_ROT_L      = 14'h3F00;
   localparam logic [13:0] VAL_ROT_L      = 14'h0D00;
   // Bit positions: opcode destination select, interrupt enable in control register, data top bit
   localparam int DEST_BIT    = 7;
   localparam int IRQ_EN_BIT  = 7;
   localparam int MSB_BIT     = 7;
   // Reset values
   localparam logic [7:0]  RST_IRQ_CTRL   = 8'h00;
   localparam logic [7:0]  RST_ACC        = 8'h00;
   localparam logic [12:0] RST_PC         = 13'h0000;
   // Cycles per instruction
   localparam logic [1:0]  CYC_RETURN     = 2'h2;
   localparam logic [1:0]  CYC_ROTATE     = 2'h1;

   typedef enum logic [2:0]
   {
      OP_NONE   = 3'b000,
      OP_IRQ_RET = 3'b001,
      OP_RETURN  = 3'b010,
      OP_LIT_RET = 3'b011,
      OP_ROT_L   = 3'b100
   } rrie_op_t;

   typedef enum logic
   {
      ST_IDLE   = 1'b0,
      ST_SECOND = 1'b1
   } rrie_state_t;

   // Arithmetic status flags
   typedef struct packed
   {
      logic zero;
      logic digit_carry;
      logic carry;
   } rrie_flags_t;

   // Instruction issue with the addressed file register's value
   typedef struct packed
   {
      logic                 valid;
      logic [OPC_W-1:0]     opcode;
      logic [DATA_W-1:0]    file_rd_data;
   } rrie_req_t;

   // File register write back
   typedef struct packed
   {
      logic                 en;
      logic [FADDR_W-1:0]   addr;
      logic [DATA_W-1:0]    data;
   } rrie_fwr_t;
endpackage : rrie_pkg

// ---- verif/tb_return_rotate_instr_exec.sv ----
// Self-checking bench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module tb_return_rotate_instr_exec;
   import rrie_pkg::*;
   logic        core_clk, rst_n, flags_wr_en, irq_ctrl_wr_en;
   rrie_req_t   req;
   logic [12:0] stack_top, pc, pc_m;
   rrie_flags_t flags_wr_data, flags, flg_m;
   logic [7:0]  irq_ctrl_wr_data, acc, irq_control_reg, acc_m, fd;
   logic        ready, instr_done, stack_pop;
   rrie_fwr_t   file_wr;
   logic [8:0]  rr;
   logic [13:0] op;
   int          fails, cmp_count, seed;

   rrie_exec uut
   (
      .core_clk         (core_clk),
      .rst_n            (rst_n),
      .req              (req),
      .stack_top        (stack_top),
      .flags_wr_en      (flags_wr_en),
      .flags_wr_data    (flags_wr_data),
      .irq_ctrl_wr_en   (irq_ctrl_wr_en),
      .irq_ctrl_wr_data (irq_ctrl_wr_data),
      .ready            (ready),
      .instr_done       (instr_done),
      .stack_pop        (stack_pop),
      .pc               (pc),
      .acc              (acc),
      .flags            (flags),
      .irq_control_reg  (irq_control_reg),
      .file_wr          (file_wr)
   );

   // Clock at 40 MHz
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic wrap_up;
      $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // Expected rotate: {new carry, result}
   function automatic logic [8:0] rot(input logic [7:0] v, input logic c);
      return {v[7], v[6:0], c};
   endfunction : rot

   // Load random flags and control register, control bit 7 cleared
   task automatic preload;
      flg_m            = rrie_flags_t'(3'($random(seed)));
      flags_wr_en      = 1'b1;
      flags_wr_data    = flg_m;
      irq_ctrl_wr_en   = 1'b1;
      irq_ctrl_wr_data = {1'b0, 7'($random(seed))};
      @(negedge core_clk);
      flags_wr_en    = 1'b0;
      irq_ctrl_wr_en = 1'b0;
      chk(32'(flags), 32'(flg_m));
      chk(irq_control_reg, irq_ctrl_wr_data);
   endtask : preload

   // One return, with a request held during the busy cycle that must be ignored
   task automatic do_ret(input logic [13:0] o);
      logic [12:0] t;
      t         = 13'($random(seed));
      req       = '{1'b1, o, 8'hE6};
      stack_top = t;
      @(negedge core_clk);
      req.opcode = 14'h0D00;
      stack_top  = ~t;
      irq_ctrl_wr_en = 1'b0;
      pc_m       = t;
      if (o[13:10] == 4'hD)
         acc_m = o[7:0];
      chk(stack_pop, 1);
      chk(ready, 0);
      chk(pc, t);
      chk(32'(flags), 32'(flg_m));
      chk(acc, acc_m);
      if (o == 14'h0009)
         chk(irq_control_reg, irq_ctrl_wr_data | 8'h80);
      @(negedge core_clk);
      req.valid = 1'b0;
      chk(instr_done, 1);
      chk(ready, 1);
      chk(stack_pop, 0);
      chk(acc, acc_m);
      chk(32'(flags), 32'(flg_m));
      @(negedge core_clk);
      chk(instr_done, 0);
   endtask : do_ret

   // Back-to-back rotates, corner values first
   task automatic do_rot(input int n);
      for (int i = 0; i < n; i++)
      begin
         fd  = (i == 0) ? 8'hE6 : (i == 1) ? 8'h80 : (i == 2) ? 8'h7F : 8'($random(seed));
         op  = {6'h0D, 1'($random(seed)), 7'($random(seed))};
         req = '{1'b1, op, fd};
         // Corner: flag load in the same cycle, rotate carry wins
         if (i == 3)
         begin
            flags_wr_en   = 1'b1;
            flags_wr_data = rrie_flags_t'(3'($random(seed)));
         end
         @(negedge core_clk);
         rr          = rot(fd, flg_m.carry);
         if (i == 3)
         begin
            flags_wr_en = 1'b0;
            flg_m       = flags_wr_data;
         end
         flg_m.carry = rr[8];
         chk(instr_done, 1);
         chk(32'(flags), 32'(flg_m));
         if (op[7])
            chk(32'(file_wr), {16'h0, 1'b1, op[6:0], rr[7:0]});
         else
         begin
            acc_m = rr[7:0];
            chk(file_wr.en, 0);
         end
         chk(acc, acc_m);
      end
      req.valid = 1'b0;
   endtask : do_rot

   // Main sequence
   initial
   begin
      seed = 32'h54D55E1E;
      fails = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      req = '0;
      stack_top = '0;
      flags_wr_en = 1'b0;
      flags_wr_data = '0;
      irq_ctrl_wr_en = 1'b0;
      irq_ctrl_wr_data = '0;
      acc_m = '0;
      flg_m = '0;
      pc_m = '0;
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      chk(ready, 1);
      chk(pc, 0);
      chk(acc, 0);
      chk(32'(flags), 0);
      chk(irq_control_reg, 0);
      chk(32'(file_wr), 0);
      $display("test reset done");
      for (int j = 0; j < 6; j++)
      begin
         preload;
         do_ret(14'h0009);
         // Corner: control write in the same cycle as an interrupt return
         if (j[0])
         begin
            irq_ctrl_wr_en   = 1'b1;
            irq_ctrl_wr_data = {1'b0, 7'($random(seed))};
            do_ret(14'h0009);
         end
         do_ret(14'h0008);
         do_ret({4'hD, 2'($random(seed)), 8'($random(seed))});
         // Corner: undecoded opcode finishes in one cycle with no effect
         req = '{1'b1, 14'h0064, 8'hE6};
         @(negedge core_clk);
         chk(instr_done, 1);
         chk(ready, 1);
         chk(stack_pop, 0);
         chk(pc, pc_m);
         chk(acc, acc_m);
         chk(32'(flags), 32'(flg_m));
         chk(file_wr.en, 0);
         do_rot(20);
         $display("test round %0d done", j);
      end
      wrap_up;
   end

   // Watchdog against a hang
   initial
   begin
      #200000;
      fails++;
      $display("test timeout");
      wrap_up;
   end
endmodule : tb_return_rotate_instr_exec
`default_nettype wire
